//--- logic/tfd_map.svh
// Register addresses, command codes, field positions and reset values
`ifndef TFD_MAP_SVH
`define TFD_MAP_SVH
// ---------------------------------------------
// Command block addresses
// ---------------------------------------------
`define TFD_A_DATA 3'h0
`define TFD_A_ERRFEAT 3'h1
`define TFD_A_COUNT 3'h2
`define TFD_A_SECTOR 3'h3
`define TFD_A_CYL_LO 3'h4
`define TFD_A_CYL_HI 3'h5
`define TFD_A_DRVHEAD 3'h6
`define TFD_A_STATCMD 3'h7
// ---------------------------------------------
// Control block addresses
// ---------------------------------------------
`define TFD_A_ALTCTL 3'h6
`define TFD_A_OBSOLETE 3'h7
// ---------------------------------------------
// Fields
// ---------------------------------------------
`define TFD_DH_DRV 4
`define TFD_HEAD_MSB 3
// ---------------------------------------------
// Command codes
// ---------------------------------------------
`define TFD_C_STANDBY 8'he2
`define TFD_C_STANDBY_IMM 8'he0
`define TFD_C_WRITE_BUF 8'he8
`define TFD_C_WRITE_DMA 8'hca
`define TFD_C_WRITE_DMA_Q 8'hcc
`define TFD_C_WRITE_MULT 8'hc5
`define TFD_C_WRITE_SECT 8'h30
`define TFD_C_DIAG 8'h90
`define TFD_C_PACKET 8'ha0
`define TFD_C_SERVICE 8'ha2
`define TFD_C_VS_9A 8'h9a
`define TFD_C_VS_F0 8'hf0
`define TFD_C_VS_F7 8'hf7
`define TFD_C_VS_FA 8'hfa
`define TFD_C_VS_C0 8'hc0
`define TFD_C_VS_C3 8'hc3
`define TFD_C_VS_8X 4'h8
// ---------------------------------------------
// Reset values and buffer shape
// ---------------------------------------------
`define TFD_RST_BYTE 8'h00
`define TFD_RST_DEVCTL 8'h00
`define TFD_FIFO_WIDTH 16
`define TFD_FIFO_DEPTH 16
`endif

//--- logic/tfd_pkg.sv
// Types shared by the taskfile decoder
`default_nettype none
package tfd_pkg;
    typedef enum logic [6:0] {
        TFD_P_NONE = 7'h01,
        TFD_P_NON_DATA = 7'h02,
        TFD_P_PIO_OUT = 7'h04,
        TFD_P_DMA = 7'h08,
        TFD_P_QUEUED_DMA = 7'h10,
        TFD_P_DIAG = 7'h20,
        TFD_P_PACKET = 7'h40
    } tfd_proto_t;
    typedef enum logic [4:0] {
        TFD_K_MANDATORY = 5'h01,
        TFD_K_OPTIONAL = 5'h02,
        TFD_K_VENDOR = 5'h04,
        TFD_K_RESERVED = 5'h08,
        TFD_K_NOT_USED = 5'h10
    } tfd_kind_t;
    typedef enum logic [4:0] {
        TFD_DH_NONE = 5'h01,
        TFD_DH_FULL = 5'h02,
        TFD_DH_DEVICE = 5'h04,
        TFD_DH_VENDOR = 5'h08,
        TFD_DH_BOTH_EXEC = 5'h10
    } tfd_dh_use_t;
    // params: features, count, sector, cylinder, drive/head
    typedef struct packed {
        logic [7:0] code;
        tfd_proto_t proto;
        tfd_kind_t kind;
        logic [4:0] params;
        tfd_dh_use_t dh_use;
    } tfd_cmd_info_t;
    typedef struct packed {
        logic [7:0] features;
        logic [7:0] count;
        logic [7:0] sector;
        logic [15:0] cylinder;
        logic drive;
        logic [3:0] head;
    } tfd_operands_t;
endpackage
`default_nettype wire

//--- logic/tfd_taskfile.sv
// Taskfile register decode, command classifier and data buffer
// Notes on behaviour
// RULE1: No select or bad control address: float on reads, ignore writes.
// RULE2: Command block decodes data through status/command in address order.
// RULE3: Packet mode: interrupt reason, byte counts, device select replace taskfile.
// RULE4: Obsolete control address never drives the bus; writes dropped.
// RULE5: Host never asserts both selects; such a cycle selects nothing.
// RULE6: Standby commands are non-data; write buffer is optional PIO out.
// RULE7: Write DMA, queued DMA, write multiple and write sectors classed.
// RULE8: Listed vendor codes are vendor specific; other unknown codes reserved.
// RULE9: Packet-capable device refuses not-to-be-used commands, keeps standby immediate.
// RULE10: Valid parameter registers become operands; full drive/head keeps head.
// RULE11: Device-only commands honour drive bit and zero the head.
// RULE12: Vendor head usage honours drive bit, passes head bits through.
// RULE13: Diagnostic runs on both devices whatever drive is selected.
// RULE14: Command packet layout is illustrative and lies outside this block.
`timescale 1ns/100ps
`default_nettype none
`include "tfd_map.svh"

module tfd_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign in_ready_out = count != (AW+1)'(DEPTH);
    assign out_valid_out = count != '0;
    assign out_data_out = mem[rd_ptr];
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;

    always_ff @(posedge clk_in)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module tfd_taskfile (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic cs0_n_in,
    input wire logic cs1_n_in,
    input wire logic [2:0] da_in,
    input wire logic host_read_n_in,
    input wire logic host_write_n_in,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe_out,
    input wire logic packet_mode_in,
    input wire logic packet_feature_in,
    input wire logic dev_num_in,
    input wire logic [7:0] status_in,
    input wire logic [7:0] error_in,
    input wire logic [7:0] int_reason_in,
    input wire logic [15:0] core_read_data_in,
    output logic core_read_ack_out,
    output logic data_space_out,
    output logic core_wr_valid_out,
    input wire logic core_wr_ready_in,
    output logic [15:0] core_wr_data_out,
    output logic [7:0] dev_control_out,
    output logic cmd_strobe_out,
    output logic cmd_reject_out,
    output tfd_pkg::tfd_cmd_info_t cmd_info_out,
    output tfd_pkg::tfd_operands_t cmd_operands_out
);
    // ---------------------------------------------
    // Strobes and selection
    // ---------------------------------------------
    logic rd_prev;
    logic wr_prev;
    logic rd_fall;
    logic wr_fall;
    logic sel_cmd;
    logic sel_ctl;
    logic [7:0] features;
    logic [7:0] count;
    logic [7:0] sector;
    logic [7:0] cyl_lo;
    logic [7:0] cyl_hi;
    logic [7:0] drv_head;
    logic next_oe;
    logic [15:0] next_data;
    logic fifo_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    tfd_pkg::tfd_cmd_info_t next_info;
    logic next_accept;

    assign rd_fall = rd_prev && !host_read_n_in;
    assign wr_fall = wr_prev && !host_write_n_in;
    assign sel_cmd = !cs0_n_in && cs1_n_in; // RULE5
    assign sel_ctl = cs0_n_in && !cs1_n_in; // RULE5

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            rd_prev <= 1'b1;
            wr_prev <= 1'b1;
        end
        else
        begin
            rd_prev <= host_read_n_in;
            wr_prev <= host_write_n_in;
        end
    end

    // ---------------------------------------------
    // Read path
    // ---------------------------------------------
    always_comb
    begin
        next_oe = 1'b0;
        next_data = 16'h0000;
        if (!host_read_n_in && sel_cmd)
        begin
            next_oe = 1'b1;
            unique case (da_in) // RULE2
                `TFD_A_DATA: next_data = core_read_data_in;
                `TFD_A_ERRFEAT: next_data = {8'h00, error_in};
                `TFD_A_COUNT: next_data = {8'h00, packet_mode_in ? int_reason_in : count}; // RULE3
                `TFD_A_SECTOR:
                begin
                    next_oe = !packet_mode_in; // RULE3
                    next_data = {8'h00, packet_mode_in ? 8'h00 : sector};
                end
                `TFD_A_CYL_LO: next_data = {8'h00, cyl_lo};
                `TFD_A_CYL_HI: next_data = {8'h00, cyl_hi};
                `TFD_A_DRVHEAD: next_data = {8'h00, drv_head};
                `TFD_A_STATCMD: next_data = {8'h00, status_in};
            endcase
        end
        else if (!host_read_n_in && sel_ctl && da_in == `TFD_A_ALTCTL)
        begin
            next_oe = 1'b1; // RULE1
            next_data = {8'h00, status_in};
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            data_oe_out <= 1'b0;
            data_out <= 16'h0000;
            core_read_ack_out <= 1'b0;
        end
        else
        begin
            data_oe_out <= next_oe; // RULE1 RULE4
            data_out <= next_data;
            core_read_ack_out <= rd_fall && sel_cmd && da_in == `TFD_A_DATA;
        end
    end

    // ---------------------------------------------
    // Register writes
    // ---------------------------------------------
    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            features <= `TFD_RST_BYTE;
            count <= `TFD_RST_BYTE;
            sector <= `TFD_RST_BYTE;
            cyl_lo <= `TFD_RST_BYTE;
            cyl_hi <= `TFD_RST_BYTE;
            drv_head <= `TFD_RST_BYTE;
        end
        else if (wr_fall && sel_cmd)
        begin
            unique case (da_in) // RULE2 RULE3
                `TFD_A_ERRFEAT: features <= data_in[7:0];
                `TFD_A_COUNT: count <= packet_mode_in ? count : data_in[7:0];
                `TFD_A_SECTOR: sector <= packet_mode_in ? sector : data_in[7:0];
                `TFD_A_CYL_LO: cyl_lo <= data_in[7:0];
                `TFD_A_CYL_HI: cyl_hi <= data_in[7:0];
                `TFD_A_DRVHEAD: drv_head <= data_in[7:0];
                default:
                begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            dev_control_out <= `TFD_RST_DEVCTL;
        end
        else if (wr_fall && sel_ctl && da_in == `TFD_A_ALTCTL)
        begin
            dev_control_out <= data_in[7:0]; // RULE1 RULE4
        end
    end

    // ---------------------------------------------
    // Data buffer
    // ---------------------------------------------
    tfd_fifo #(
        .WIDTH(`TFD_FIFO_WIDTH),
        .DEPTH(`TFD_FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(wr_fall && sel_cmd && da_in == `TFD_A_DATA),
        .in_ready_out(fifo_ready),
        .in_data_in(data_in),
        .out_valid_out(fifo_out_valid),
        .out_ready_in(core_wr_ready_in),
        .out_data_out(fifo_out_data)
    );
    assign core_wr_valid_out = fifo_out_valid;
    assign core_wr_data_out = fifo_out_data;

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            data_space_out <= 1'b0;
        end
        else
        begin
            data_space_out <= fifo_ready;
        end
    end

    // ---------------------------------------------
    // Command classifier
    // ---------------------------------------------
    function automatic tfd_pkg::tfd_cmd_info_t classify(input logic [7:0] c, input logic pkt);
        tfd_pkg::tfd_cmd_info_t r;
        r.code = c;
        r.proto = tfd_pkg::TFD_P_NONE;
        r.kind = tfd_pkg::TFD_K_RESERVED; // RULE8
        r.params = 5'h00;
        r.dh_use = tfd_pkg::TFD_DH_NONE;
        unique case (c)
            `TFD_C_STANDBY:
            begin
                r.proto = tfd_pkg::TFD_P_NON_DATA; // RULE6
                r.kind = pkt ? tfd_pkg::TFD_K_OPTIONAL : tfd_pkg::TFD_K_MANDATORY;
                r.params = 5'h09;
                r.dh_use = tfd_pkg::TFD_DH_DEVICE;
            end
            `TFD_C_STANDBY_IMM:
            begin
                r.proto = tfd_pkg::TFD_P_NON_DATA; // RULE6
                r.kind = tfd_pkg::TFD_K_MANDATORY; // RULE9
                r.params = 5'h01;
                r.dh_use = tfd_pkg::TFD_DH_DEVICE;
            end
            `TFD_C_WRITE_BUF:
            begin
                r.proto = tfd_pkg::TFD_P_PIO_OUT; // RULE6
                r.kind = pkt ? tfd_pkg::TFD_K_NOT_USED : tfd_pkg::TFD_K_OPTIONAL;
                r.params = 5'h01;
                r.dh_use = tfd_pkg::TFD_DH_DEVICE;
            end
            `TFD_C_WRITE_DMA, `TFD_C_WRITE_MULT, `TFD_C_WRITE_SECT:
            begin
                r.proto = c == `TFD_C_WRITE_DMA ? tfd_pkg::TFD_P_DMA : tfd_pkg::TFD_P_PIO_OUT; // RULE7
                r.kind = pkt ? tfd_pkg::TFD_K_NOT_USED : tfd_pkg::TFD_K_MANDATORY; // RULE9
                r.params = 5'h0f;
                r.dh_use = tfd_pkg::TFD_DH_FULL;
            end
            `TFD_C_WRITE_DMA_Q:
            begin
                r.proto = tfd_pkg::TFD_P_QUEUED_DMA; // RULE7
                r.kind = pkt ? tfd_pkg::TFD_K_NOT_USED : tfd_pkg::TFD_K_OPTIONAL;
                r.params = 5'h1f;
                r.dh_use = tfd_pkg::TFD_DH_FULL;
            end
            `TFD_C_DIAG:
            begin
                r.proto = tfd_pkg::TFD_P_DIAG;
                r.kind = tfd_pkg::TFD_K_MANDATORY;
                r.params = 5'h01;
                r.dh_use = tfd_pkg::TFD_DH_BOTH_EXEC; // RULE13
            end
            `TFD_C_PACKET, `TFD_C_SERVICE:
            begin
                r.proto = tfd_pkg::TFD_P_PACKET;
                r.kind = !pkt ? tfd_pkg::TFD_K_NOT_USED :
                         c == `TFD_C_PACKET ? tfd_pkg::TFD_K_MANDATORY : tfd_pkg::TFD_K_OPTIONAL;
                r.params = 5'h1f;
                r.dh_use = tfd_pkg::TFD_DH_DEVICE;
            end
            default:
            begin
                if (c == `TFD_C_VS_9A || c == `TFD_C_VS_F0 || c == `TFD_C_VS_F7 ||
                    c >= `TFD_C_VS_FA || c[7:4] == `TFD_C_VS_8X ||
                    (c >= `TFD_C_VS_C0 && c <= `TFD_C_VS_C3))
                begin
                    r.kind = tfd_pkg::TFD_K_VENDOR; // RULE8
                    r.dh_use = tfd_pkg::TFD_DH_VENDOR;
                    r.params = 5'h01;
                end
            end
        endcase
        return r;
    endfunction

    always_comb
    begin
        next_info = classify(data_in[7:0], packet_feature_in);
        next_accept = next_info.kind != tfd_pkg::TFD_K_NOT_USED &&
                      next_info.kind != tfd_pkg::TFD_K_RESERVED; // RULE9
    end

    always_ff @(posedge clk_in)
    begin
        if (!reset_n_in)
        begin
            cmd_strobe_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            cmd_info_out <= '0;
            cmd_operands_out <= '0;
        end
        else
        begin
            cmd_strobe_out <= 1'b0;
            cmd_reject_out <= 1'b0;
            if (wr_fall && sel_cmd && da_in == `TFD_A_STATCMD &&
                (drv_head[`TFD_DH_DRV] == dev_num_in ||
                 next_info.dh_use == tfd_pkg::TFD_DH_BOTH_EXEC)) // RULE13
            begin
                cmd_strobe_out <= next_accept;
                cmd_reject_out <= !next_accept; // RULE9
                cmd_info_out <= next_info;
                cmd_operands_out.features <= next_info.params[4] ? features : 8'h00; // RULE10
                cmd_operands_out.count <= next_info.params[3] ? count : 8'h00;
                cmd_operands_out.sector <= next_info.params[2] ? sector : 8'h00;
                cmd_operands_out.cylinder <= next_info.params[1] ? {cyl_hi, cyl_lo} : 16'h0000;
                cmd_operands_out.drive <= drv_head[`TFD_DH_DRV]; // RULE11 RULE12
                cmd_operands_out.head <= (next_info.dh_use == tfd_pkg::TFD_DH_FULL ||
                    next_info.dh_use == tfd_pkg::TFD_DH_VENDOR) ?
                    drv_head[`TFD_HEAD_MSB:0] : 4'h0; // RULE10 RULE11 RULE12
            end
        end
    end

    // ---------------------------------------------
    // Checks
    // ---------------------------------------------
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!reset_n_in);

    no_select_float_a: assert property (cs0_n_in && cs1_n_in |=> !data_oe_out) // RULE1
        else $error("bus driven with no select");
    both_select_float_a: assert property (!cs0_n_in && !cs1_n_in |=> !data_oe_out) // RULE5
        else $error("bus driven on invalid address");
    obsolete_read_float_a: assert property (sel_ctl && da_in == `TFD_A_OBSOLETE
        |=> !data_oe_out) // RULE4
        else $error("obsolete address drove bus");
    alt_status_read_a: assert property (!host_read_n_in && sel_ctl && da_in == `TFD_A_ALTCTL
        |=> data_oe_out && data_out == {8'h00, $past(status_in)}) // RULE1
        else $error("alternate status read wrong");
    status_read_a: assert property (!host_read_n_in && sel_cmd && da_in == `TFD_A_STATCMD
        |=> data_oe_out && data_out[7:0] == $past(status_in)) // RULE2
        else $error("status read wrong");
    int_reason_read_a: assert property (!host_read_n_in && sel_cmd && packet_mode_in &&
        da_in == `TFD_A_COUNT |=> data_out[7:0] == $past(int_reason_in)) // RULE3
        else $error("interrupt reason read wrong");
    standby_class_a: assert property (cmd_strobe_out && cmd_info_out.code == `TFD_C_STANDBY
        |-> cmd_info_out.proto == tfd_pkg::TFD_P_NON_DATA && cmd_info_out.params[3]) // RULE6
        else $error("standby misclassified");
    dma_class_a: assert property (cmd_strobe_out && cmd_info_out.code == `TFD_C_WRITE_DMA
        |-> cmd_info_out.proto == tfd_pkg::TFD_P_DMA) // RULE7
        else $error("write dma misclassified");
    vendor_class_a: assert property (cmd_reject_out || cmd_strobe_out
        |-> (cmd_info_out.code == `TFD_C_VS_9A) == (cmd_info_out.code == `TFD_C_VS_9A &&
        cmd_info_out.kind == tfd_pkg::TFD_K_VENDOR)) // RULE8
        else $error("vendor code misclassified");
    pkt_refuse_a: assert property (wr_fall && sel_cmd && da_in == `TFD_A_STATCMD &&
        packet_feature_in && data_in[7:0] == `TFD_C_WRITE_DMA && drv_head[4] == dev_num_in
        |=> cmd_reject_out && !cmd_strobe_out) // RULE9
        else $error("not-to-be-used command accepted");
    head_zero_a: assert property (cmd_strobe_out && cmd_info_out.dh_use ==
        tfd_pkg::TFD_DH_DEVICE |-> cmd_operands_out.head == 4'h0) // RULE11
        else $error("head not ignored");
    head_kept_a: assert property (cmd_strobe_out && cmd_info_out.dh_use == tfd_pkg::TFD_DH_FULL
        |-> cmd_operands_out.head == drv_head[3:0]) // RULE10
        else $error("head operand lost");
    diag_both_a: assert property (wr_fall && sel_cmd && da_in == `TFD_A_STATCMD &&
        data_in[7:0] == `TFD_C_DIAG |=> cmd_strobe_out) // RULE13
        else $error("diagnostic not executed");

    dma_cmd_c: cover property (cmd_strobe_out && cmd_info_out.proto == tfd_pkg::TFD_P_DMA);
    reject_c: cover property (cmd_reject_out);
    fifo_full_c: cover property (!data_space_out);
endmodule

`default_nettype wire

//--- verification/tfd_host_model.sv
// Host adapter model driving selects, address, strobes and write data
`timescale 1ns/100ps
`default_nettype none
module tfd_host_model (
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic oe_in,
    output logic cs0_n_out,
    output logic cs1_n_out,
    output logic [2:0] da_out,
    output logic read_n_out,
    output logic write_n_out,
    output logic [15:0] data_out
);
    initial
    begin
        {cs1_n_out, cs0_n_out} = 2'h3;
        da_out = 3'h0;
        read_n_out = 1'b1;
        write_n_out = 1'b1;
        data_out = 16'h0000;
    end
    // One write cycle; csn is {cs1_n, cs0_n}
    task automatic wr(input logic [1:0] csn, input logic [2:0] a, input logic [15:0] d);
        @(posedge clk_in);
        {cs1_n_out, cs0_n_out} <= csn;
        da_out <= a;
        data_out <= d;
        write_n_out <= 1'b0;
        @(posedge clk_in);
        write_n_out <= 1'b1;
        @(posedge clk_in);
        {cs1_n_out, cs0_n_out} <= 2'h3;
        data_out <= ~d;
    endtask
    // One read cycle; q is {drive enable, read data}
    task automatic rd(input logic [1:0] csn, input logic [2:0] a, output logic [16:0] q);
        @(posedge clk_in);
        {cs1_n_out, cs0_n_out} <= csn;
        da_out <= a;
        read_n_out <= 1'b0;
        repeat (2) @(posedge clk_in);
        #1 q = {oe_in, rdata_in};
        @(posedge clk_in);
        read_n_out <= 1'b1;
        {cs1_n_out, cs0_n_out} <= 2'h3;
    endtask
endmodule
`default_nettype wire

//--- verification/taskfile_register_decode_tb_top.sv
// Self-checking bench for the taskfile decoder
`timescale 1ns/100ps
`default_nettype none
module taskfile_register_decode_tb_top;
    logic clk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic pkt_mode = 1'b0, pkt_feat = 1'b0, dev_num = 1'b0, wr_ready = 1'b0;
    logic [7:0] st = 8'h50, er = 8'h04, ir = 8'h03;
    logic [15:0] crd = 16'h1234;
    logic cs0_n, cs1_n, rd_n, wr_n, doe, space, wv, cstb, crej, rack;
    logic [2:0] da;
    logic [15:0] hd, dout, wd;
    logic [7:0] devctl;
    logic [16:0] q;
    tfd_pkg::tfd_cmd_info_t info;
    tfd_pkg::tfd_operands_t ops;
    int errors = 0, n_compared = 0, n_acc = 0, n_rej = 0, n_rack = 0, cyc = 0, k;
    logic [7:0] codes [12] = '{8'he2, 8'he0, 8'he8, 8'hca, 8'hcc, 8'hc5, 8'h30,
        8'h9a, 8'hc3, 8'h85, 8'hf7, 8'hfa};
    // Kind: 01 mandatory, 02 optional, 04 vendor
    logic [4:0] kinds [12] = '{5'h01, 5'h01, 5'h02, 5'h01, 5'h02, 5'h01, 5'h01,
        5'h04, 5'h04, 5'h04, 5'h04, 5'h04};
    // Protocol: 02 non-data, 04 pio out, 08 dma, 10 queued dma
    logic [6:0] protos [7] = '{7'h02, 7'h02, 7'h04, 7'h08, 7'h10, 7'h04, 7'h04};

    tfd_taskfile dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .cs0_n_in(cs0_n),
        .cs1_n_in(cs1_n), .da_in(da), .host_read_n_in(rd_n), .host_write_n_in(wr_n),
        .data_in(hd), .data_out(dout), .data_oe_out(doe), .packet_mode_in(pkt_mode),
        .packet_feature_in(pkt_feat), .dev_num_in(dev_num), .status_in(st), .error_in(er),
        .int_reason_in(ir), .core_read_data_in(crd), .core_read_ack_out(rack),
        .data_space_out(space), .core_wr_valid_out(wv), .core_wr_ready_in(wr_ready),
        .core_wr_data_out(wd), .dev_control_out(devctl), .cmd_strobe_out(cstb),
        .cmd_reject_out(crej), .cmd_info_out(info), .cmd_operands_out(ops));
    tfd_host_model host (.clk_in(clk_in), .rdata_in(dout), .oe_in(doe), .cs0_n_out(cs0_n),
        .cs1_n_out(cs1_n), .da_out(da), .read_n_out(rd_n), .write_n_out(wr_n),
        .data_out(hd));

    initial
    begin
        forever #25 clk_in = ~clk_in;
    end
    always @(posedge clk_in)
    begin
        cyc++;
        if (cstb === 1'b1) n_acc++;
        if (crej === 1'b1) n_rej++;
        if (rack === 1'b1) n_rack++;
        if (cyc == 5000)
        begin
            errors++;
            close_out();
        end
    end

    task automatic close_out;
        if (errors == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        n_compared++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // Read and compare; data is only compared when the bus is expected to be driven
    task automatic rdc(input logic [1:0] csn, input logic [2:0] a, input logic [16:0] e);
        host.rd(csn, a, q);
        chk("read drive", e[16], q[16]);
        if (e[16])
            chk("read data", e[15:0], q[15:0]);
    endtask
    // Command write, then count accepted and refused pulses
    task automatic cmdc(input logic [7:0] c, input int acc, input int rej);
        int na, nr;
        na = n_acc;
        nr = n_rej;
        host.wr(2'h2, 3'h7, {8'h00, c});
        #1;
        chk("accepted", acc, n_acc - na);
        chk("refused", rej, n_rej - nr);
    endtask

    initial
    begin
        repeat (2) @(posedge clk_in);
        reset_n_in <= 1'b1;
        @(posedge clk_in);
        rdc(2'h2, 3'h2, 17'h10000);
        chk("devctl reset", 8'h00, devctl);
        for (int a = 1; a < 7; a++) host.wr(2'h2, a[2:0], 16'h0010 + a);
        for (int a = 0; a < 8; a++)
            rdc(2'h2, a[2:0], {1'b1, a == 0 ? crd : a == 1 ? {8'h00, er} :
                a == 7 ? {8'h00, st} : 16'h0010 + a[15:0]});
        chk("read ack", 1, n_rack);
        for (int a = 0; a < 8; a++) rdc(2'h3, a[2:0], 17'h00000);
        for (int a = 0; a < 8; a++) rdc(2'h1, a[2:0], {a == 6, 8'h00, st});
        for (int a = 0; a < 8; a++) rdc(2'h0, a[2:0], 17'h00000);
        host.wr(2'h1, 3'h6, 16'h000a);
        host.wr(2'h1, 3'h5, 16'h00ff);
        host.wr(2'h1, 3'h7, 16'h00ff);
        chk("devctl", 8'h0a, devctl);
        host.wr(2'h3, 3'h2, 16'h0099);
        host.wr(2'h0, 3'h2, 16'h0099);
        rdc(2'h2, 3'h2, 17'h10012);
        @(posedge clk_in) pkt_mode <= 1'b1;
        rdc(2'h2, 3'h2, {9'h100, ir});
        rdc(2'h2, 3'h3, 17'h00000);
        host.wr(2'h2, 3'h4, 16'h0077);
        host.wr(2'h2, 3'h2, 16'h0055);
        rdc(2'h2, 3'h4, 17'h10077);
        rdc(2'h2, 3'h5, 17'h10015);
        rdc(2'h2, 3'h6, 17'h10016);
        rdc(2'h2, 3'h7, {9'h100, st});
        @(posedge clk_in) pkt_mode <= 1'b0;
        rdc(2'h2, 3'h2, 17'h10012);
        host.wr(2'h2, 3'h6, 16'h000a);
        for (int i = 0; i < 12; i++)
        begin
            cmdc(codes[i], 1, 0);
            chk("kind", kinds[i], info.kind);
            if (i < 7) chk("proto", protos[i], info.proto);
        end
        cmdc(8'h01, 0, 1);
        @(posedge clk_in) pkt_feat <= 1'b1;
        cmdc(8'hca, 0, 1);
        cmdc(8'hc5, 0, 1);
        cmdc(8'he0, 1, 0);
        chk("kind", 5'h01, info.kind);
        cmdc(8'ha0, 1, 0);
        @(posedge clk_in) pkt_feat <= 1'b0;
        cmdc(8'ha2, 0, 1);
        for (int a = 1; a < 6; a++) host.wr(2'h2, a[2:0], 16'h0011 * a);
        cmdc(8'hcc, 1, 0);
        chk("operands", 45'h224466aa88a, ops);
        cmdc(8'he2, 1, 0);
        chk("operands", 45'h000440000000, ops);
        cmdc(8'h9a, 1, 0);
        chk("head", 4'ha, ops.head);
        chk("drive", 1'b0, ops.drive);
        host.wr(2'h2, 3'h6, 16'h0010);
        cmdc(8'hca, 0, 0);
        cmdc(8'h90, 1, 0);
        chk("dh use", 5'h10, info.dh_use);
        chk("code", 8'h90, info.code);
        for (int i = 0; i < 17; i++) host.wr(2'h2, 3'h0, 16'ha000 + i);
        repeat (2) @(posedge clk_in);
        chk("space", 1'b0, space);
        wr_ready <= 1'b1;
        k = 0;
        repeat (40)
        begin
            @(posedge clk_in);
            if (wv === 1'b1 && wr_ready === 1'b1)
            begin
                chk("fifo word", 16'ha000 + k, wd);
                k++;
            end
        end
        chk("fifo count", 16, k);
        chk("space", 1'b1, space);
        close_out();
    end
endmodule
`default_nettype wire
